// file: ecsc_pkg.sv
package ecsc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int UNLOCK_WINDOW_MS = 10;
   localparam int UNLOCK_WINDOW_CYC = UNLOCK_WINDOW_MS * CLK_MHZ * 1000;
   localparam int NV_OP_CYC = 64;
   localparam int BIST_CYC = 32;
   localparam int CLKMON_MIN_TOGGLES = 2;
   localparam int SCLK_HALF = 8;
   localparam int FRAME_BITS = 24;
   localparam int HEAD_BITS = 8;
   localparam int EE_BYTES = 17;
   localparam int CFG_BYTES = 24;
   localparam int SHADOW_WORDS = 10;
   localparam logic [15:0] KEY0 = 16'h000F;
   localparam logic [15:0] KEY1 = 16'h0055;
   localparam logic [15:0] KEY2 = 16'h00AA;
   localparam logic [15:0] KEY3 = 16'h00F0;
   localparam logic [7:0] CMD_PROGRAM = 8'hA7;
   localparam logic [7:0] CMD_RELOAD = 8'hA2;
   localparam logic [7:0] CMD_DONE = 8'h00;
   localparam logic [7:0] CRC_SEED = 8'hFF;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [6:0] A_THR1 = 7'h00;
   localparam logic [6:0] A_THR6 = 7'h05;
   localparam logic [6:0] A_LOOP = 7'h06;
   localparam logic [6:0] A_AFE = 7'h07;
   localparam logic [6:0] A_PHASE = 7'h08;
   localparam logic [6:0] A_GEN = 7'h09;
   localparam logic [6:0] A_CTRL1 = 7'h0A;
   localparam logic [6:0] A_CTRL2 = 7'h0B;
   localparam logic [6:0] A_EEPROM_COMMAND = 7'h0C;
   localparam logic [6:0] A_UNLK = 7'h0D;
   localparam logic [6:0] A_EECRC = 7'h0E;
   localparam logic [6:0] A_STAT1 = 7'h0F;
   localparam logic [6:0] A_STAT4 = 7'h10;
   localparam logic [6:0] A_CHECKSUM_CHECK_ENABLE = 7'h11;
   localparam logic [6:0] A_GOOD = 7'h12;
   localparam logic [6:0] A_CALC = 7'h13;
   localparam int CTRL2_ABIST_BIT = 0;
   localparam int CTRL2_LBIST_BIT = 1;
   localparam int STAT1_CFGF_BIT = 0;
   localparam int STAT4_LBIST_BIT = 0;
   localparam int STAT4_ABIST_BIT = 1;
   localparam int CHECKSUM_CHECK_ENABLE_EN_BIT = 0;
   localparam int UNLK_OPEN_BIT = 0;
   localparam logic [9:0][15:0] NV_FACTORY = {16'h0002, 16'h1400, 16'h0005, 16'h0514,
      16'h038F, 16'h1C00, 16'h07E2, 16'hFCFF, 16'h00ED, 16'h8B40};
   localparam logic [3:0][15:0] LBIST_PAT = {16'hAAAA, 16'h5555, 16'hFFFF, 16'h0000};

   typedef enum logic [1:0] {
      ECSC_IDLE = 2'b00,
      ECSC_NVOP = 2'b01,
      ECSC_EECRC = 2'b10,
      ECSC_CFGCRC = 2'b11
   } ecsc_state_e;

   // One byte of the checksum, bits taken most significant first.
   function automatic logic [7:0] ecsc_crc8_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      logic fb;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         fb = x[7] ^ d[i];
         x = {x[6:0], 1'h0} ^ (fb ? CRC_POLY : 8'h00);
      end
      return x;
   endfunction
endpackage

// file: ecsc_link_if.sv
`timescale 1ns/10ps
interface ecsc_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport host (output sclk, output cs_n, output mosi, input miso);
   modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface

// file: ecsc_device.sv
// Added by the designer: the serial link port and the register addresses.
`timescale 1ns/10ps
module ecsc_device #(
   parameter int UNLOCK_WINDOW_CYC = ecsc_pkg::UNLOCK_WINDOW_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   ecsc_link_if.dev link,
   input wire logic diag_state,
   input wire logic analog_trip,
   input wire logic clock_monitor_in,
   output logic selftest_stimulus,
   output logic clock_fail_emulate,
   output logic config_checksum_fault,
   output logic eeprom_busy
);
   typedef struct packed {
      logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2;
      logic cmon_s1, cmon_s2, cmon_s3, trip_s1, trip_s2;
      logic [4:0] bit_cnt;
      logic [22:0] rx;
      logic [15:0] tx;
      logic miso;
      logic [9:0][15:0] shadow;
      logic [9:0][15:0] nv;
      logic [15:0] ctrl1;
      logic [3:0] ctrl2_hi;
      logic [7:0] good, calc, eecrc, crc, cmd;
      logic crc_en, cfg_fault, unlocked, op_prog, boot_pend, diag_prev;
      logic [1:0] unlock_idx;
      logic [21:0] unlock_tmr;
      ecsc_pkg::ecsc_state_e st;
      logic [6:0] op_cnt;
      logic [4:0] byte_idx;
      logic abist_run, lbist_run, abist_f, lbist_f, trip_seen;
      logic [1:0] tog_cnt;
      logic [5:0] abist_cnt;
      logic [2:0] lbist_cnt;
      logic [15:0] lb_pat;
      logic lbf_acc;
   } ecsc_dev_s;

   ecsc_dev_s r_reg;
   ecsc_dev_s r_next;
   logic [135:0] ee_str;
   logic [191:0] cfg_str;
   logic [5:0] ctrl2_live;
   logic [15:0] rd_word;
   logic [7:0] head;
   logic [23:0] frame;
   logic rise;
   logic fall;
   logic [7:0] crc_byte;
   localparam logic [6:0] A_GEN_IDX = ecsc_pkg::A_GEN;

   assign ctrl2_live = {r_reg.ctrl2_hi, r_reg.lbist_run, r_reg.abist_run};
   assign ee_str = {32'h0, r_reg.shadow[9][8:7], r_reg.shadow[9][5:0], r_reg.shadow[4][12:10],
      r_reg.shadow[7][3:0], r_reg.shadow[1][8:0], r_reg.shadow[3][10:5], r_reg.shadow[5][9:0],
      r_reg.shadow[3][4:0], r_reg.shadow[6][10:0], r_reg.shadow[8], r_reg.shadow[0],
      r_reg.shadow[2]};
   assign cfg_str = {r_reg.shadow[0], 7'h0, r_reg.shadow[1][8:0], r_reg.shadow[2], 5'h0,
      r_reg.shadow[3][10:0], 3'h0, r_reg.shadow[4][12:10], 10'h0, 6'h0, r_reg.shadow[5][9:0],
      5'h0, r_reg.shadow[6][10:0], 12'h0, r_reg.shadow[7][3:0], r_reg.shadow[8], 7'h0,
      r_reg.shadow[9][8:7], 1'h0, r_reg.shadow[9][5:0], 2'h0, r_reg.ctrl1[13], 1'h0,
      r_reg.ctrl1[11:0], 10'h0, ctrl2_live};
   assign rise = r_reg.sclk_s2 & ~r_reg.sclk_s3 & ~r_reg.cs_s2;
   assign fall = ~r_reg.sclk_s2 & r_reg.sclk_s3 & ~r_reg.cs_s2;
   assign head = {r_reg.rx[6:0], r_reg.mosi_s2};
   assign frame = {r_reg.rx, r_reg.mosi_s2};

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_word = 16'h0000;
      if (head[6:0] <= A_GEN_IDX) begin
         rd_word = r_reg.shadow[head[3:0]];
      end else begin
         case (head[6:0])
            ecsc_pkg::A_CTRL1: rd_word = r_reg.ctrl1;
            ecsc_pkg::A_CTRL2: rd_word = {10'h0, ctrl2_live};
            ecsc_pkg::A_EEPROM_COMMAND: rd_word = {8'h00, r_reg.cmd};
            ecsc_pkg::A_UNLK: rd_word = {15'h0, r_reg.unlocked};
            ecsc_pkg::A_EECRC: rd_word = {8'h00, r_reg.eecrc};
            ecsc_pkg::A_STAT1: rd_word = {15'h0, r_reg.cfg_fault};
            ecsc_pkg::A_STAT4: rd_word = {14'h0, r_reg.abist_f, r_reg.lbist_f};
            ecsc_pkg::A_CHECKSUM_CHECK_ENABLE: rd_word = {15'h0, r_reg.crc_en};
            ecsc_pkg::A_GOOD: rd_word = {8'h00, r_reg.good};
            ecsc_pkg::A_CALC: rd_word = {8'h00, r_reg.calc};
            default: rd_word = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_next = r_reg;
      crc_byte = 8'h00;
      // Pins from the far end are sampled twice before any use.
      r_next.sclk_s1 = link.sclk;
      r_next.sclk_s2 = r_reg.sclk_s1;
      r_next.sclk_s3 = r_reg.sclk_s2;
      r_next.cs_s1 = link.cs_n;
      r_next.cs_s2 = r_reg.cs_s1;
      r_next.mosi_s1 = link.mosi;
      r_next.mosi_s2 = r_reg.mosi_s1;
      r_next.cmon_s1 = clock_monitor_in;
      r_next.cmon_s2 = r_reg.cmon_s1;
      r_next.cmon_s3 = r_reg.cmon_s2;
      r_next.trip_s1 = analog_trip;
      r_next.trip_s2 = r_reg.trip_s1;
      r_next.diag_prev = diag_state;

      // Unlock window; an expired partial sequence starts over.
      if (r_reg.unlock_idx != 2'h0) begin
         r_next.unlock_tmr = r_reg.unlock_tmr + 22'h000001;
         if (r_reg.unlock_tmr >= 22'(UNLOCK_WINDOW_CYC - 1)) begin
            r_next.unlock_idx = 2'h0;
         end
      end

      // Serial link framing.
      if (r_reg.cs_s2) begin
         r_next.bit_cnt = 5'h00;
         r_next.miso = 1'h0;
      end else if (rise) begin
         r_next.rx = frame[22:0];
         r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
         if (r_reg.bit_cnt == 5'(ecsc_pkg::HEAD_BITS - 1)) begin
            r_next.tx = rd_word;
         end
         if (r_reg.bit_cnt == 5'(ecsc_pkg::FRAME_BITS - 1) && frame[23]) begin
            if (frame[22:16] <= A_GEN_IDX) begin
               r_next.shadow[frame[19:16]] = frame[15:0];
            end
            case (frame[22:16])
               ecsc_pkg::A_CTRL1: r_next.ctrl1 = frame[15:0];
               ecsc_pkg::A_CTRL2: begin
                  r_next.ctrl2_hi = frame[5:2];
                  if (frame[ecsc_pkg::CTRL2_ABIST_BIT] && !r_reg.abist_run) begin
                     r_next.abist_run = 1'h1;
                     r_next.abist_cnt = 6'h00;
                     r_next.trip_seen = 1'h0;
                     r_next.tog_cnt = 2'h0;
                  end
                  if (frame[ecsc_pkg::CTRL2_LBIST_BIT] && !r_reg.lbist_run) begin
                     r_next.lbist_run = 1'h1;
                     r_next.lbist_cnt = 3'h0;
                     r_next.lbf_acc = 1'h0;
                  end
               end
               ecsc_pkg::A_EEPROM_COMMAND: begin
                  if (r_reg.unlocked && r_reg.st != ecsc_pkg::ECSC_NVOP
                     && r_reg.st != ecsc_pkg::ECSC_EECRC
                     && (frame[7:0] == ecsc_pkg::CMD_PROGRAM
                     || frame[7:0] == ecsc_pkg::CMD_RELOAD)) begin
                     r_next.cmd = frame[7:0];
                     r_next.op_prog = (frame[7:0] == ecsc_pkg::CMD_PROGRAM);
                     r_next.st = ecsc_pkg::ECSC_NVOP;
                     r_next.op_cnt = 7'h00;
                  end
               end
               ecsc_pkg::A_UNLK: begin
                  if (!diag_state) begin
                     r_next.unlock_idx = 2'h0;
                  end else if (frame[15:0] == key_at(r_reg.unlock_idx)) begin
                     r_next.unlock_idx = r_reg.unlock_idx + 2'h1;
                     if (r_reg.unlock_idx == 2'h0) begin
                        r_next.unlock_tmr = 22'h000000;
                     end
                     if (r_reg.unlock_idx == 2'h3) begin
                        r_next.unlocked = 1'h1;
                     end
                  end else begin
                     r_next.unlocked = 1'h0;
                     r_next.unlock_tmr = 22'h000000;
                     r_next.unlock_idx = (frame[15:0] == ecsc_pkg::KEY0) ? 2'h1 : 2'h0;
                  end
               end
               ecsc_pkg::A_CHECKSUM_CHECK_ENABLE: r_next.crc_en = frame[ecsc_pkg::CHECKSUM_CHECK_ENABLE_EN_BIT];
               ecsc_pkg::A_GOOD: r_next.good = frame[7:0];
               default: ;
            endcase
         end
      end else if (fall && r_reg.bit_cnt >= 5'(ecsc_pkg::HEAD_BITS)) begin
         r_next.miso = r_reg.tx[15];
         r_next.tx = {r_reg.tx[14:0], 1'h0};
      end

      if (!diag_state) begin
         r_next.unlocked = 1'h0;
         r_next.unlock_idx = 2'h0;
      end

      // Self-tests start on every entry into diagnostics.
      if (diag_state && !r_reg.diag_prev) begin
         r_next.abist_run = 1'h1;
         r_next.abist_cnt = 6'h00;
         r_next.trip_seen = 1'h0;
         r_next.tog_cnt = 2'h0;
         r_next.lbist_run = 1'h1;
         r_next.lbist_cnt = 3'h0;
         r_next.lbf_acc = 1'h0;
      end else begin
         if (r_reg.abist_run) begin
            r_next.abist_cnt = r_reg.abist_cnt + 6'h01;
            r_next.trip_seen = r_reg.trip_seen | r_reg.trip_s2;
            if ((r_reg.cmon_s2 ^ r_reg.cmon_s3) && r_reg.tog_cnt != 2'h3) begin
               r_next.tog_cnt = r_reg.tog_cnt + 2'h1;
            end
            if (r_reg.abist_cnt == 6'(ecsc_pkg::BIST_CYC - 1)) begin
               r_next.abist_run = 1'h0;
               r_next.abist_f = !(r_reg.trip_seen
                  && r_reg.tog_cnt >= 2'(ecsc_pkg::CLKMON_MIN_TOGGLES));
            end
         end
         if (r_reg.lbist_run) begin
            r_next.lbist_cnt = r_reg.lbist_cnt + 3'h1;
            if (r_reg.lbist_cnt != 3'h4) begin
               r_next.lb_pat = ecsc_pkg::LBIST_PAT[r_reg.lbist_cnt[1:0]];
            end
            if (r_reg.lbist_cnt != 3'h0
               && r_reg.lb_pat != ecsc_pkg::LBIST_PAT[2'(r_reg.lbist_cnt - 3'h1)]) begin
               r_next.lbf_acc = 1'h1;
            end
            if (r_reg.lbist_cnt == 3'h4) begin
               r_next.lbist_run = 1'h0;
               r_next.lbist_f = r_next.lbf_acc;
            end
         end
      end

      // Memory operations and the shared checksum engine.
      case (r_reg.st)
         ecsc_pkg::ECSC_IDLE: begin
            if (r_reg.boot_pend && diag_state) begin
               r_next.boot_pend = 1'h0;
               r_next.op_prog = 1'h0;
               r_next.op_cnt = 7'h00;
               r_next.st = ecsc_pkg::ECSC_NVOP;
            end else if (r_reg.crc_en && r_next.st == ecsc_pkg::ECSC_IDLE) begin
               // A memory command taken in this cycle must not be lost to a checksum pass.
               r_next.st = ecsc_pkg::ECSC_CFGCRC;
               r_next.byte_idx = 5'h00;
               r_next.crc = ecsc_pkg::CRC_SEED;
            end
         end
         ecsc_pkg::ECSC_NVOP: begin
            r_next.op_cnt = r_reg.op_cnt + 7'h01;
            if (r_reg.op_cnt == 7'(ecsc_pkg::NV_OP_CYC - 1)) begin
               if (r_reg.op_prog) begin
                  r_next.nv = r_reg.shadow;
               end else begin
                  r_next.shadow = r_reg.nv;
               end
               r_next.st = ecsc_pkg::ECSC_EECRC;
               r_next.byte_idx = 5'h00;
               r_next.crc = ecsc_pkg::CRC_SEED;
            end
         end
         ecsc_pkg::ECSC_EECRC: begin
            crc_byte = ecsc_pkg::ecsc_crc8_byte(r_reg.crc, ee_str[{r_reg.byte_idx, 3'h0} +: 8]);
            r_next.crc = crc_byte;
            r_next.byte_idx = r_reg.byte_idx + 5'h01;
            if (r_reg.byte_idx == 5'(ecsc_pkg::EE_BYTES - 1)) begin
               r_next.eecrc = crc_byte;
               r_next.cmd = ecsc_pkg::CMD_DONE;
               r_next.st = ecsc_pkg::ECSC_IDLE;
            end
         end
         ecsc_pkg::ECSC_CFGCRC: begin
            crc_byte = ecsc_pkg::ecsc_crc8_byte(r_reg.crc, cfg_str[{r_reg.byte_idx, 3'h0} +: 8]);
            r_next.crc = crc_byte;
            r_next.byte_idx = r_reg.byte_idx + 5'h01;
            if (r_next.st != ecsc_pkg::ECSC_CFGCRC) begin
               r_next.crc = ecsc_pkg::CRC_SEED;
            end else if (!r_reg.crc_en) begin
               r_next.st = ecsc_pkg::ECSC_IDLE;
            end else if (r_reg.byte_idx == 5'(ecsc_pkg::CFG_BYTES - 1)) begin
               r_next.calc = crc_byte;
               r_next.cfg_fault = (crc_byte != r_reg.good);
               r_next.st = ecsc_pkg::ECSC_IDLE;
            end
         end
         default: r_next.st = ecsc_pkg::ECSC_IDLE;
      endcase
      if (!r_reg.crc_en) begin
         r_next.cfg_fault = 1'h0;
      end
   end

   function automatic logic [15:0] key_at(input logic [1:0] i);
      case (i)
         2'h0: return ecsc_pkg::KEY0;
         2'h1: return ecsc_pkg::KEY1;
         2'h2: return ecsc_pkg::KEY2;
         default: return ecsc_pkg::KEY3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Memory content starts at factory values; a real array would simply retain it.
   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.nv <= ecsc_pkg::NV_FACTORY;
         r_reg.shadow <= ecsc_pkg::NV_FACTORY;
         r_reg.cs_s1 <= 1'h1;
         r_reg.cs_s2 <= 1'h1;
         r_reg.crc <= ecsc_pkg::CRC_SEED;
         r_reg.boot_pend <= 1'h1;
         r_reg.st <= ecsc_pkg::ECSC_IDLE;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign link.miso = r_reg.miso;
   assign selftest_stimulus = r_reg.abist_run;
   assign clock_fail_emulate = r_reg.abist_run;
   assign config_checksum_fault = r_reg.cfg_fault;
   assign eeprom_busy = (r_reg.st == ecsc_pkg::ECSC_NVOP) || (r_reg.st == ecsc_pkg::ECSC_EECRC);
endmodule // ecsc_device

// file: ecsc_host.sv
`timescale 1ns/10ps
module ecsc_host (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   ecsc_link_if.host link,
   input wire logic req,
   input wire logic req_write,
   input wire logic [6:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [15:0] rdata
);
   typedef struct packed {
      logic busy, done, cs_n, sclk, mosi, miso_s1, miso_s2;
      logic [3:0] div;
      logic [5:0] half;
      logic [23:0] tx;
      logic [15:0] rx, rdata;
   } ecsc_host_s;

   ecsc_host_s r_reg;
   ecsc_host_s r_next;
   logic [5:0] nh;

   ////////////////////////////////////////////////////////////////////////////////
   // The link clock is divided down here; every half period is SCLK_HALF cycles.
   always_comb begin
      r_next = r_reg;
      nh = r_reg.half + 6'h01;
      r_next.done = 1'h0;
      r_next.miso_s1 = link.miso;
      r_next.miso_s2 = r_reg.miso_s1;
      if (!r_reg.busy) begin
         if (req) begin
            r_next.busy = 1'h1;
            r_next.cs_n = 1'h0;
            r_next.tx = {req_write, req_addr, req_wdata};
            r_next.mosi = req_write;
            r_next.half = 6'h00;
            r_next.div = 4'h0;
         end
      end else begin
         r_next.div = r_reg.div + 4'h1;
         if (r_reg.div == 4'(ecsc_pkg::SCLK_HALF - 1)) begin
            r_next.div = 4'h0;
            r_next.half = nh;
            if (nh < 6'(2 * ecsc_pkg::FRAME_BITS)) begin
               if (nh[0]) begin
                  r_next.sclk = 1'h1;
                  if (nh[5:1] >= 5'(ecsc_pkg::HEAD_BITS)) begin
                     r_next.rx = {r_reg.rx[14:0], r_reg.miso_s2};
                  end
               end else begin
                  r_next.sclk = 1'h0;
                  r_next.tx = {r_reg.tx[22:0], 1'h0};
                  r_next.mosi = r_reg.tx[22];
               end
            end else if (nh == 6'(2 * ecsc_pkg::FRAME_BITS)) begin
               r_next.sclk = 1'h0;
            end else if (nh == 6'(2 * ecsc_pkg::FRAME_BITS + 1)) begin
               r_next.cs_n = 1'h1;
               r_next.mosi = 1'h0;
            end else begin
               r_next.busy = 1'h0;
               r_next.done = 1'h1;
               r_next.rdata = r_reg.rx;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.cs_n <= 1'h1;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign link.sclk = r_reg.sclk;
   assign link.cs_n = r_reg.cs_n;
   assign link.mosi = r_reg.mosi;
   assign busy = r_reg.busy;
   assign done = r_reg.done;
   assign rdata = r_reg.rdata;
endmodule // ecsc_host

// file: ecsc_link_monitor.sv
`timescale 1ns/10ps
module ecsc_link_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   // Counts link clock rises within a frame, because a short frame is silently dropped.
   logic sclk_d_reg;
   logic [5:0] rise_reg;
   always_ff @(posedge clk) begin
      sclk_d_reg <= sclk;
      if (reset || cs_n) begin
         rise_reg <= 6'h00;
      end else if (sclk && !sclk_d_reg) begin
         rise_reg <= rise_reg + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_idle; cs_n |-> !sclk; endproperty
   a_idle: assert property (p_idle) else $error("link clock runs outside a frame");
   property p_quiet; cs_n [*5] |-> !miso; endproperty
   a_quiet: assert property (p_quiet) else $error("reply line busy between frames");
   property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
   a_gap: assert property (p_gap) else $error("frames too close");
   property p_half; $changed(sclk) |=> $stable(sclk) [*7]; endproperty
   a_half: assert property (p_half) else $error("link clock half period wrong");
   property p_mosi; !cs_n && $changed(mosi) |-> $fell(sclk) || $fell(cs_n); endproperty
   a_mosi: assert property (p_mosi) else $error("data moved off a falling edge");
   property p_len; $fell(cs_n) |-> ##[380:400] $rose(cs_n); endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   property p_bits; $rose(cs_n) |-> rise_reg == 6'h18; endproperty
   a_bits: assert property (p_bits) else $error("frame without 24 clock rises");
   property p_miso; !cs_n && $changed(miso) |-> !sclk; endproperty
   a_miso: assert property (p_miso) else $error("reply moved while clock high");
endmodule // ecsc_link_monitor

// file: test_eeprom_crc_selftest_control.sv
`timescale 1ns/10ps
module test_eeprom_crc_selftest_control;
   localparam int WIN = 3000;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic req = 1'h0;
   logic req_write = 1'h0;
   logic [6:0] req_addr = 7'h00;
   logic [15:0] req_wdata = 16'h0000;
   logic diag_state = 1'h1;
   logic analog_trip = 1'h0;
   logic clock_monitor_in = 1'h0;
   logic trip_ok = 1'h1;
   logic busy, done, selftest_stimulus, clock_fail_emulate, config_checksum_fault, eeprom_busy;
   logic [15:0] rdata, c1, c2, v;
   logic [15:0] sh [10];
   logic [7:0] g;
   logic [16:0] e;
   logic [16:0] exp_q [$];
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   integer seed = 32'haa7e4bee;
   ecsc_link_if link ();
   always #2.5 clk = ~clk;
   ecsc_host i_ecsc_host (.clk(clk), .reset(reset), .ce(1'h1), .link(link), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
      .done(done), .rdata(rdata));
   ecsc_device #(.UNLOCK_WINDOW_CYC(WIN)) i_ecsc_device (.clk(clk), .reset(reset), .ce(1'h1),
      .link(link), .diag_state(diag_state), .analog_trip(analog_trip),
      .clock_monitor_in(clock_monitor_in), .selftest_stimulus(selftest_stimulus),
      .clock_fail_emulate(clock_fail_emulate), .config_checksum_fault(config_checksum_fault),
      .eeprom_busy(eeprom_busy));
   ecsc_link_monitor i_ecsc_link_monitor (.clk(clk), .reset(reset), .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
   ////////////////////////////////////////////////////////////////////////////////
   // Comparators echo the stimulus unless a fault is wanted; the monitor toggles at random.
   always @(posedge clk) begin
      analog_trip <= trip_ok & selftest_stimulus;
      clock_monitor_in <= clock_fail_emulate & 1'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         end_of_test();
      end
   end
   always @(posedge clk) begin
      if (done === 1'h1) begin
         e = exp_q.pop_front();
         if (e[16]) begin
            comparisons = comparisons + 1;
            if (rdata !== e[15:0]) begin
               errors = errors + 1;
               $display("Error at %0t expected %h got %h", $time, e[15:0], rdata);
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] crc8(input logic [191:0] s, input int n);
      logic [7:0] c;
      c = 8'hFF;
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ s[8 * k + i]) ? 8'h07 : 8'h00);
         end
      end
      return c;
   endfunction
   function automatic logic [191:0] ee_str();
      return {88'h0, sh[9][8:7], sh[9][5:0], sh[4][12:10], sh[7][3:0], sh[1][8:0], sh[3][10:5],
         sh[5][9:0], sh[3][4:0], sh[6][10:0], sh[8], sh[0], sh[2]};
   endfunction
   function automatic logic [191:0] cfg_str();
      return {sh[0], 7'h0, sh[1][8:0], sh[2], 5'h0, sh[3][10:0], 3'h0, sh[4][12:10], 16'h0,
         sh[5][9:0], 5'h0, sh[6][10:0], 12'h0, sh[7][3:0], sh[8], 7'h0, sh[9][8:7], 1'h0,
         sh[9][5:0], 2'h0, c1[13], 1'h0, c1[11:0], 10'h0, c2[5:0]};
   endfunction
   task automatic op(input logic w, input logic [6:0] a, input logic [15:0] d,
      input logic [16:0] x);
      int n;
      exp_q.push_back(x);
      @(posedge clk);
      req <= 1'h1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req <= 1'h0;
      n = 0;
      while (done !== 1'h1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (n == 500) errors = errors + 1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      comparisons = comparisons + 1;
      if (got !== want) begin
         errors = errors + 1;
         $display("Error at %0t expected %h got %h", $time, want, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      op(1'h1, a, d, 17'h00000);
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] x);
      op(1'h0, a, 16'h0000, {1'h1, x});
   endtask
   task automatic unlock();
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY0);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY1);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY2);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY3);
   endtask
   task automatic end_of_test();
      $display("TB counts: errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 10; i++) sh[i] = ecsc_pkg::NV_FACTORY[i];
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      repeat (150) @(posedge clk);
      rd(ecsc_pkg::A_EEPROM_COMMAND, 16'h0000);
      rd(ecsc_pkg::A_EECRC, {8'h00, crc8(ee_str(), 17)});
      rd(ecsc_pkg::A_STAT4, 16'h0000);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY0);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY1);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY3);
      rd(ecsc_pkg::A_UNLK, 16'h0000);
      unlock();
      rd(ecsc_pkg::A_UNLK, 16'h0001);
      v = 16'($random(seed));
      sh[0] = v;
      wr(ecsc_pkg::A_THR1, v);
      wr(ecsc_pkg::A_EEPROM_COMMAND, {8'h00, ecsc_pkg::CMD_PROGRAM});
      chk({14'h0, eeprom_busy, busy}, 16'h0002);
      rd(ecsc_pkg::A_EEPROM_COMMAND, 16'h0000);
      rd(ecsc_pkg::A_EECRC, {8'h00, crc8(ee_str(), 17)});
      wr(ecsc_pkg::A_THR1, ~v);
      unlock();
      wr(ecsc_pkg::A_EEPROM_COMMAND, {8'h00, ecsc_pkg::CMD_RELOAD});
      rd(ecsc_pkg::A_THR1, v);
      diag_state <= 1'h0;
      unlock();
      rd(ecsc_pkg::A_UNLK, 16'h0000);
      diag_state <= 1'h1;
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY0);
      repeat (WIN) @(posedge clk);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY1);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY2);
      wr(ecsc_pkg::A_UNLK, ecsc_pkg::KEY3);
      rd(ecsc_pkg::A_UNLK, 16'h0000);
      c1 = 16'($random(seed));
      c2 = {10'h000, 4'($random(seed)), 2'h0};
      wr(ecsc_pkg::A_CTRL1, c1);
      wr(ecsc_pkg::A_CTRL2, c2);
      g = crc8(cfg_str(), 24);
      wr(ecsc_pkg::A_GOOD, {8'h00, g});
      wr(ecsc_pkg::A_CHECKSUM_CHECK_ENABLE, 16'h0001);
      rd(ecsc_pkg::A_STAT1, 16'h0000);
      rd(ecsc_pkg::A_CALC, {8'h00, g});
      wr(ecsc_pkg::A_GOOD, {8'h00, g ^ 8'h01});
      rd(ecsc_pkg::A_STAT1, 16'h0001);
      chk({15'h0, config_checksum_fault}, 16'h0001);
      wr(ecsc_pkg::A_CHECKSUM_CHECK_ENABLE, 16'h0000);
      rd(ecsc_pkg::A_STAT1, 16'h0000);
      chk({15'h0, config_checksum_fault}, 16'h0000);
      wr(ecsc_pkg::A_CTRL2, c2 | 16'h0003);
      rd(ecsc_pkg::A_CTRL2, c2);
      rd(ecsc_pkg::A_STAT4, 16'h0000);
      trip_ok <= 1'h0;
      wr(ecsc_pkg::A_CTRL2, c2 | 16'h0001);
      rd(ecsc_pkg::A_STAT4, 16'h0002);
      end_of_test();
   end
endmodule // test_eeprom_crc_selftest_control
